//--- verilog/cpt_capture_output.sv
// Capture, output control and event generation of the control PWM timer
`include "cpt_params.svh"
`default_nettype none
module cpt_capture_output #(
    parameter int CNT_W = `CPT_CNT_W
) (
    input  wire logic                  i_clock,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_por,
    input  wire logic [7:0]            i_timer_output_fuse,
    input  wire logic [CNT_W-1:0]      i_counter,
    input  wire logic                  i_event_a,
    input  wire logic                  i_event_b,
    input  wire logic                  i_action_a,
    input  wire logic                  i_action_b,
    input  wire logic                  i_sw_snapshot_strobe_a,
    input  wire logic                  i_sw_snapshot_strobe_b,
    input  wire logic                  i_read_a_low,
    input  wire logic                  i_read_b_low,
    input  wire logic                  i_flag_clr_a,
    input  wire logic                  i_flag_clr_b,
    input  wire logic                  i_irq_enable_a,
    input  wire logic                  i_irq_enable_b,
    input  wire logic                  i_unlock_key,
    input  wire logic                  i_instr_step,
    input  wire logic                  i_fault_wr,
    input  wire logic [7:0]            i_fault_wdata,
    input  wire logic                  i_fault_active,
    input  wire logic                  i_dither_ovf,
    input  wire logic                  i_dither_in_dtb,
    input  wire logic [1:0]            i_phase_a,
    input  wire logic [1:0]            i_phase_b,
    input  wire logic                  i_out_c_source_sel,
    input  wire logic                  i_out_d_source_sel,
    input  wire logic                  i_manual_level_override,
    input  wire logic [3:0]            i_manual_levels_a,
    input  wire logic [3:0]            i_manual_levels_b,
    input  wire logic [CNT_W-1:0]      i_a_set_cmp,
    input  wire logic [CNT_W-1:0]      i_a_clr_cmp,
    input  wire logic [CNT_W-1:0]      i_b_set_cmp,
    input  wire logic [CNT_W-1:0]      i_b_clr_cmp,
    input  wire cpt_pkg::cpt_src_type  i_prog_src,
    input  wire logic [7:0]            i_prog_delay,
    output logic [7:0]                 o_snapshot_a_low_byte,
    output logic [7:0]                 o_snapshot_a_high_byte,
    output logic [7:0]                 o_snapshot_b_low_byte,
    output logic [7:0]                 o_snapshot_b_high_byte,
    output logic                       o_input_a_hit_flag,
    output logic                       o_input_b_hit_flag,
    output logic                       o_irq,
    output logic                       o_command_done,
    output logic                       o_input_mode_kick_a,
    output logic                       o_input_mode_kick_b,
    output logic [7:0]                 o_output_fault_config,
    output logic                       o_dtb_stretch,
    output logic                       o_otb_shorten,
    output logic                       o_wave_out_a,
    output logic                       o_wave_out_b,
    output logic                       o_wave_out_c,
    output logic                       o_wave_out_d,
    output logic                       o_b_clear_match,
    output logic                       o_a_set_match,
    output logic                       o_b_set_match,
    output logic                       o_programmable_out_event
);
    import cpt_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [1:0]       ev_a_s;
        logic [1:0]       ev_b_s;
        logic             ev_a_d;
        logic             ev_b_d;
        logic [CNT_W-1:0] cap_a;
        logic [CNT_W-1:0] cap_b;
        logic [7:0]       hi_a;
        logic [7:0]       hi_b;
        logic             flag_a;
        logic             flag_b;
        logic             busy;
        logic [7:0]       fault;
        logic [2:0]       unlock;
        logic             kick_a;
        logic             kick_b;
        logic             m_bclr;
        logic             m_aset;
        logic             m_bset;
        logic             prog_pend;
        logic [7:0]       prog_cnt;
        logic             prog_ev;
        logic [3:0]       wave;
        logic             dith;
    } cpt_state_type;

    cpt_state_type st_r;
    cpt_state_type st_nxt;
    logic          rise_a;
    logic          rise_b;
    logic          cap_a_go;
    logic          cap_b_go;
    logic          prog_hit;
    logic          lvl_a;
    logic          lvl_b;
    logic          lvl_c;
    logic          lvl_d;

    // Phase code: 0 dead time low bit, 1 on time, chosen by field index
    function automatic logic phase_level(input logic [3:0] f, input logic [1:0] ph);
        phase_level = f[ph];
    endfunction : phase_level

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_nxt = st_r;
        // Event pins cross from the event system: two flops first
        st_nxt.ev_a_s = {st_r.ev_a_s[0], i_event_a};
        st_nxt.ev_b_s = {st_r.ev_b_s[0], i_event_b};
        st_nxt.ev_a_d = st_r.ev_a_s[1];
        st_nxt.ev_b_d = st_r.ev_b_s[1];
        rise_a = st_r.ev_a_s[1] & ~st_r.ev_a_d;
        rise_b = st_r.ev_b_s[1] & ~st_r.ev_b_d;
        cap_a_go = (rise_a & i_action_a) | i_sw_snapshot_strobe_a;
        cap_b_go = (rise_b & i_action_b) | i_sw_snapshot_strobe_b;
        // Counter only seen through the capture registers
        if (cap_a_go) begin
            st_nxt.cap_a = i_counter;
        end
        if (cap_b_go) begin
            st_nxt.cap_b = i_counter;
        end
        // High byte frozen at low-byte read so the pair is coherent
        if (i_read_a_low) begin
            st_nxt.hi_a = 8'(st_r.cap_a >> 8);
        end
        if (i_read_b_low) begin
            st_nxt.hi_b = 8'(st_r.cap_b >> 8);
        end
        // Set wins over clear
        st_nxt.flag_a = (rise_a & i_action_a) | (st_r.flag_a & ~i_flag_clr_a);
        st_nxt.flag_b = (rise_b & i_action_b) | (st_r.flag_b & ~i_flag_clr_b);
        st_nxt.busy = i_sw_snapshot_strobe_a | i_sw_snapshot_strobe_b;
        // Same event drives capture and the input-mode logic
        st_nxt.kick_a = rise_a;
        st_nxt.kick_b = rise_b;
        // Protected write window counts instruction steps after the key
        if (i_unlock_key) begin
            st_nxt.unlock = `CPT_UNLOCK_WIN;
        end else if (st_r.unlock != 3'h0 && i_instr_step) begin
            st_nxt.unlock = st_r.unlock - 3'h1;
        end
        if (i_fault_wr && st_r.unlock != 3'h0) begin
            st_nxt.fault = i_fault_wdata;
            st_nxt.unlock = 3'h0;
        end
        st_nxt.m_bclr = (i_counter == i_b_clr_cmp);
        st_nxt.m_aset = (i_counter == i_a_set_cmp);
        st_nxt.m_bset = (i_counter == i_b_set_cmp);
        unique case (i_prog_src)
            CPT_SRC_TRIG: prog_hit = rise_a | rise_b;
            CPT_SRC_ACLR: prog_hit = (i_counter == i_a_clr_cmp);
            CPT_SRC_ASET: prog_hit = st_nxt.m_aset;
            CPT_SRC_BSET: prog_hit = st_nxt.m_bset;
            default:      prog_hit = st_nxt.m_bclr;
        endcase
        st_nxt.prog_ev = 1'b0;
        if (st_r.prog_pend) begin
            if (st_r.prog_cnt == 8'h00) begin
                st_nxt.prog_ev = 1'b1;
                st_nxt.prog_pend = 1'b0;
            end else begin
                st_nxt.prog_cnt = st_r.prog_cnt - 8'h01;
            end
        end else if (prog_hit) begin
            if (i_prog_delay == 8'h00) begin
                st_nxt.prog_ev = 1'b1;
            end else begin
                st_nxt.prog_pend = 1'b1;
                st_nxt.prog_cnt = i_prog_delay - 8'h01;
            end
        end
        // One-ramp: A and B only see their own phase fields; C and D copy A or B
        lvl_a = i_manual_level_override ? phase_level(i_manual_levels_a, i_phase_a)
                                        : i_phase_a[0];
        lvl_b = i_manual_level_override ? phase_level(i_manual_levels_b, i_phase_b)
                                        : i_phase_b[0];
        lvl_c = (i_out_c_source_sel == `CPT_SEL_FROM_A) ? lvl_a : lvl_b;
        lvl_d = (i_out_d_source_sel == `CPT_SEL_FROM_A) ? lvl_a : lvl_b;
        // Each pin has its own fault level, so C and D do not follow A or B here
        if (i_fault_active) begin
            lvl_a = st_r.fault[0];
            lvl_b = st_r.fault[1];
            lvl_c = st_r.fault[2];
            lvl_d = st_r.fault[3];
        end
        st_nxt.wave[0] = lvl_a & st_r.fault[4];
        st_nxt.wave[1] = lvl_b & st_r.fault[5];
        st_nxt.wave[2] = lvl_c & st_r.fault[6];
        st_nxt.wave[3] = lvl_d & st_r.fault[7];
        // Registered so the dither marks change only on clock edges
        st_nxt.dith = i_dither_ovf & i_dither_in_dtb;
        if (!i_rst_n) begin
            st_nxt = '0;
            // Fault config survives ordinary resets via the fuse image
            st_nxt.fault = i_por ? `CPT_FAULT_RST : i_timer_output_fuse;
        end
    end

    always_ff @(posedge i_clock) begin
        st_r <= st_nxt;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign o_snapshot_a_low_byte    = st_r.cap_a[7:0];
    assign o_snapshot_a_high_byte   = st_r.hi_a;
    assign o_snapshot_b_low_byte    = st_r.cap_b[7:0];
    assign o_snapshot_b_high_byte   = st_r.hi_b;
    assign o_input_a_hit_flag       = st_r.flag_a;
    assign o_input_b_hit_flag       = st_r.flag_b;
    assign o_irq = (st_r.flag_a & i_irq_enable_a) | (st_r.flag_b & i_irq_enable_b);
    assign o_command_done           = ~st_r.busy;
    assign o_input_mode_kick_a      = st_r.kick_a;
    assign o_input_mode_kick_b      = st_r.kick_b;
    assign o_output_fault_config    = st_r.fault;
    assign o_dtb_stretch            = st_r.dith;
    assign o_otb_shorten            = st_r.dith;
    assign o_wave_out_a             = st_r.wave[0];
    assign o_wave_out_b             = st_r.wave[1];
    assign o_wave_out_c             = st_r.wave[2];
    assign o_wave_out_d             = st_r.wave[3];
    assign o_b_clear_match          = st_r.m_bclr;
    assign o_a_set_match            = st_r.m_aset;
    assign o_b_set_match            = st_r.m_bset;
    assign o_programmable_out_event = st_r.prog_ev;

    // ****************************************************************
    // Checks
    // ****************************************************************
    flag_set_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (rise_a && i_action_a) |=> o_input_a_hit_flag)
        else $error("flag A not set after capture event");
    flag_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (o_input_a_hit_flag && !i_flag_clr_a) |=> o_input_a_hit_flag)
        else $error("flag A dropped without clear");
    irq_gate_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (o_input_a_hit_flag && i_irq_enable_a) |-> o_irq)
        else $error("enabled flag gives no interrupt");
    cap_load_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_sw_snapshot_strobe_a |=> (o_snapshot_a_low_byte == $past(i_counter[7:0]))
        && !o_command_done)
        else $error("software capture A wrong");
    hi_freeze_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_read_a_low |=> o_snapshot_a_high_byte == $past(st_r.cap_a[11:8]))
        else $error("high byte not frozen");
    prog_pulse_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_programmable_out_event |=> !o_programmable_out_event)
        else $error("programmable event longer than a cycle");
    locked_wr_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_fault_wr && st_r.unlock == 3'h0 && !i_unlock_key)
        |=> $stable(o_output_fault_config))
        else $error("locked fault config changed");
    gate_out_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !o_output_fault_config[4] |=> !o_wave_out_a || $past(o_output_fault_config[4]))
        else $error("disabled output driven");
    fault_lvl_c_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_fault_active && o_output_fault_config[6])
        |=> o_wave_out_c == $past(o_output_fault_config[2]))
        else $error("output C ignores its own fault level");
    dith_mark_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_dither_ovf && i_dither_in_dtb) |=> (o_dtb_stretch && o_otb_shorten))
        else $error("dither marks missing");
    cv_cap: cover property (@(posedge i_clock) rise_a && i_action_a);
    cv_sw: cover property (@(posedge i_clock) i_sw_snapshot_strobe_b);
    cv_prog: cover property (@(posedge i_clock) o_programmable_out_event);
    cv_fault: cover property (@(posedge i_clock) i_fault_active && o_wave_out_c);
    cv_delay: cover property (@(posedge i_clock) o_programmable_out_event && i_prog_delay[7]);
endmodule : cpt_capture_output
`default_nettype wire

//--- verilog/cpt_params.svh
// Constants for the capture and output control block of the control PWM timer
`ifndef CPT_PARAMS_SVH
`define CPT_PARAMS_SVH
`define CPT_CNT_W        12
`define CPT_SEL_FROM_A   1'b0
`define CPT_PROG_SRC_W   3
`define CPT_DLY_W        8
`define CPT_UNLOCK_WIN   3'h4
`define CPT_FAULT_RST    8'h00
`endif

//--- verilog/cpt_pkg.sv
// Types shared by the capture and output control block
`default_nettype none
package cpt_pkg;
    typedef enum logic [2:0] {
        CPT_SRC_TRIG  = 3'h0,
        CPT_SRC_ACLR  = 3'h1,
        CPT_SRC_ASET  = 3'h2,
        CPT_SRC_BSET  = 3'h3,
        CPT_SRC_BCLR  = 3'h4
    } cpt_src_type;
    typedef enum logic [2:0] {
        CPT_DT_A = 3'b001,
        CPT_OT_A = 3'b010,
        CPT_DT_B = 3'b100
    } cpt_phase_dummy_type;
endpackage : cpt_pkg
`default_nettype wire

//--- testbench/cpt_evt_chan.sv
// Event channel model that feeds both event inputs of the timer
`default_nettype none
module cpt_evt_chan (
    input  wire logic i_clock,
    input  wire logic i_fire,
    output logic      o_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Edges land off the bench clock, as an unrelated source would; idle low
    initial o_level = 1'b0;
    always @(posedge i_clock) begin
        if (i_fire) begin
            #7 o_level = 1'b1;
            repeat (3) @(posedge i_clock);
            #7 o_level = 1'b0;
        end
    end
endmodule : cpt_evt_chan
`default_nettype wire

//--- testbench/cpt_capture_output_tb.sv
// Self-checking bench for the capture and output control block
`default_nettype none
module cpt_capture_output_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cpt_pkg::*;
    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic i_clock, i_rst_n, i_por, i_action_a, i_action_b, i_sw_snapshot_strobe_a;
    logic i_sw_snapshot_strobe_b, i_read_a_low, i_read_b_low, i_flag_clr_a, i_flag_clr_b;
    logic i_irq_enable_a, i_irq_enable_b, i_unlock_key, i_instr_step, i_fault_wr;
    logic i_fault_active, i_dither_ovf, i_dither_in_dtb, i_out_c_source_sel;
    logic i_out_d_source_sel, i_manual_level_override, fire, chan, run, o_input_mode_kick_b;
    logic [7:0]  i_timer_output_fuse, i_fault_wdata, i_prog_delay, o_snapshot_a_low_byte;
    logic [7:0]  o_snapshot_a_high_byte, o_snapshot_b_low_byte, o_snapshot_b_high_byte;
    logic [7:0]  o_output_fault_config, cfgv[2];
    logic [11:0] i_counter, i_a_set_cmp, i_a_clr_cmp, i_b_set_cmp, i_b_clr_cmp;
    logic [1:0]  i_phase_a, i_phase_b;
    logic [3:0]  i_manual_levels_a, i_manual_levels_b, wexp;
    cpt_src_type i_prog_src;
    logic o_input_a_hit_flag, o_input_b_hit_flag, o_irq, o_command_done, o_input_mode_kick_a;
    logic o_dtb_stretch, o_otb_shorten, o_wave_out_a, o_wave_out_b, o_wave_out_c, o_wave_out_d;
    logic o_b_clear_match, o_a_set_match, o_b_set_match, o_programmable_out_event;
    int bad_count, cmp_count, nk, np, nm;
    time tm, tp;
    cpt_capture_output uut (.i_clock, .i_rst_n, .i_por, .i_timer_output_fuse, .i_counter,
        .i_event_a(chan), .i_event_b(chan), .i_action_a, .i_action_b, .i_sw_snapshot_strobe_a,
        .i_sw_snapshot_strobe_b, .i_read_a_low, .i_read_b_low, .i_flag_clr_a, .i_flag_clr_b,
        .i_irq_enable_a, .i_irq_enable_b, .i_unlock_key, .i_instr_step, .i_fault_wr,
        .i_fault_wdata, .i_fault_active, .i_dither_ovf, .i_dither_in_dtb, .i_phase_a,
        .i_phase_b, .i_out_c_source_sel, .i_out_d_source_sel, .i_manual_level_override,
        .i_manual_levels_a, .i_manual_levels_b, .i_a_set_cmp, .i_a_clr_cmp, .i_b_set_cmp,
        .i_b_clr_cmp, .i_prog_src, .i_prog_delay, .o_snapshot_a_low_byte,
        .o_snapshot_a_high_byte, .o_snapshot_b_low_byte, .o_snapshot_b_high_byte,
        .o_input_a_hit_flag, .o_input_b_hit_flag, .o_irq, .o_command_done,
        .o_input_mode_kick_a, .o_input_mode_kick_b, .o_output_fault_config, .o_dtb_stretch,
        .o_otb_shorten, .o_wave_out_a, .o_wave_out_b, .o_wave_out_c, .o_wave_out_d,
        .o_b_clear_match, .o_a_set_match, .o_b_set_match, .o_programmable_out_event);
    cpt_evt_chan chan_model (.i_clock(i_clock), .i_fire(fire), .o_level(chan));
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        if (run) i_counter <= i_counter + 12'h001;
        nk <= nk + int'(o_input_mode_kick_a) + int'(o_input_mode_kick_b);
        np <= np + int'(o_programmable_out_event);
        nm <= nm + int'(o_a_set_match) + int'(o_b_set_match) + int'(o_b_clear_match);
        if (o_a_set_match) tm <= $time;
        if (o_programmable_out_event) tp <= $time;
    end
    // ****************************************
    // Access tasks and tests
    // ****************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : cyc
    task automatic do_reset(input logic p);
        @(posedge i_clock);
        i_por <= p;
        i_rst_n <= 1'b0;
        repeat (5) @(posedge i_clock);
        i_rst_n <= 1'b1;
        cyc(0);
    endtask : do_reset
    task automatic strobe(input logic b);
        @(posedge i_clock);
        i_sw_snapshot_strobe_a <= ~b;
        i_sw_snapshot_strobe_b <= b;
        @(posedge i_clock);
        i_sw_snapshot_strobe_a <= 1'b0;
        i_sw_snapshot_strobe_b <= 1'b0;
        cyc(0);
    endtask : strobe
    task automatic rdlo(input logic b);
        @(posedge i_clock);
        i_read_a_low <= ~b;
        i_read_b_low <= b;
        @(posedge i_clock);
        i_read_a_low <= 1'b0;
        i_read_b_low <= 1'b0;
        cyc(0);
    endtask : rdlo
    // A negative step count skips the unlock key entirely
    task automatic fw(input int n, input logic [7:0] d);
        if (n >= 0) begin
            @(posedge i_clock);
            i_unlock_key <= 1'b1;
            @(posedge i_clock);
            i_unlock_key <= 1'b0;
        end
        repeat (n) begin
            @(posedge i_clock);
            i_instr_step <= 1'b1;
            @(posedge i_clock);
            i_instr_step <= 1'b0;
        end
        @(posedge i_clock);
        i_fault_wr <= 1'b1;
        i_fault_wdata <= d;
        @(posedge i_clock);
        i_fault_wr <= 1'b0;
        cyc(1);
    endtask : fw
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    initial begin
        {i_rst_n, i_por, i_action_a, i_action_b, i_sw_snapshot_strobe_a, fire, run} = '0;
        {i_sw_snapshot_strobe_b, i_read_a_low, i_read_b_low, i_flag_clr_a, i_flag_clr_b} = '0;
        {i_irq_enable_a, i_irq_enable_b, i_unlock_key, i_instr_step, i_fault_wr} = '0;
        {i_fault_active, i_dither_ovf, i_dither_in_dtb, i_out_c_source_sel} = '0;
        {i_out_d_source_sel, i_manual_level_override, i_phase_a, i_phase_b} = '0;
        {i_fault_wdata, i_prog_delay, i_manual_levels_a, i_manual_levels_b} = '0;
        {i_a_set_cmp, i_a_clr_cmp} = {12'h010, 12'h012};
        {i_b_set_cmp, i_b_clr_cmp} = {12'h014, 12'h016};
        {nk, np, nm, bad_count, cmp_count, tm, tp} = '0;
        i_timer_output_fuse = 8'h3C;
        i_counter = 12'hA5C;
        i_prog_src = CPT_SRC_TRIG;
        cfgv = '{8'hF1, 8'h5D};
        do_reset(1'b1);
        chk(o_output_fault_config, 8'h00);
        chk({o_command_done, o_input_a_hit_flag}, 2'b10);
        do_reset(1'b0);
        chk(o_output_fault_config, 8'h3C);
        strobe(1'b0);
        chk({o_command_done, o_snapshot_a_low_byte}, 9'h05C);
        cyc(1);
        chk(o_command_done, 1'b1);
        rdlo(1'b0);
        chk(o_snapshot_a_high_byte, 8'h0A);
        @(posedge i_clock);
        i_counter <= 12'h3B7;
        strobe(1'b0);
        chk({o_snapshot_a_high_byte, o_snapshot_a_low_byte}, 16'h0AB7);
        rdlo(1'b0);
        chk(o_snapshot_a_high_byte, 8'h03);
        strobe(1'b1);
        rdlo(1'b1);
        chk({o_snapshot_b_high_byte, o_snapshot_b_low_byte}, 16'h03B7);
        @(posedge i_clock);
        {i_action_a, i_irq_enable_a, i_counter, fire} <= {2'b11, 12'h6E1, 1'b1};
        @(posedge i_clock);
        fire <= 1'b0;
        cyc(0);
        nk = 0;
        for (int i = 0; i < 12 && o_input_a_hit_flag !== 1'b1; i++) cyc(1);
        cyc(3);
        chk({o_input_a_hit_flag, o_irq, o_snapshot_a_low_byte}, 10'h3E1);
        chk({o_input_b_hit_flag, o_snapshot_b_low_byte}, 9'h0B7);
        chk(16'(nk), 16'h0002);
        @(posedge i_clock);
        i_irq_enable_a <= 1'b0;
        cyc(2);
        chk(o_irq, 1'b0);
        @(posedge i_clock);
        i_irq_enable_a <= 1'b1;
        cyc(3);
        chk(o_irq, 1'b1);
        @(posedge i_clock);
        i_flag_clr_a <= 1'b1;
        @(posedge i_clock);
        i_flag_clr_a <= 1'b0;
        cyc(2);
        chk({o_input_a_hit_flag, o_irq}, 2'b00);
        fw(-1, 8'hF1);
        chk(o_output_fault_config, 8'h3C);
        fw(6, 8'hF1);
        chk(o_output_fault_config, 8'h3C);
        // Outputs track the manual fields by phase index; fault levels come from config bits 3:0
        @(posedge i_clock);
        {i_manual_level_override, i_manual_levels_a, i_manual_levels_b} <= 9'h15A;
        for (int j = 0; j < 2; j++) begin
            fw(2, cfgv[j]);
            chk(o_output_fault_config, cfgv[j]);
            for (int i = 0; i < 32; i++) begin
                @(posedge i_clock);
                {i_fault_active, i_out_d_source_sel, i_out_c_source_sel} <= i[4:2];
                {i_phase_b, i_phase_a} <= {i[2:1], i[1:0]};
                cyc(2);
                wexp[0] = 1'(4'h5 >> i[1:0]);
                wexp[1] = 1'(4'hA >> i[2:1]);
                wexp[2] = i[2] ? wexp[1] : wexp[0];
                wexp[3] = i[3] ? wexp[1] : wexp[0];
                wexp = (i[4] ? cfgv[j][3:0] : wexp) & cfgv[j][7:4];
                chk({o_wave_out_d, o_wave_out_c, o_wave_out_b, o_wave_out_a}, wexp);
            end
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge i_clock);
            {i_dither_in_dtb, i_dither_ovf} <= i[1:0];
            cyc(1);
            chk({o_dtb_stretch, o_otb_shorten}, {2{i == 3}});
        end
        for (int s = 0; s < 6; s++) begin
            @(posedge i_clock);
            i_prog_src <= cpt_src_type'((s == 5) ? 2 : s);
            i_prog_delay <= (s == 5) ? 8'hFF : 8'h00;
            i_counter <= 12'h000;
            @(posedge i_clock);
            {run, fire} <= 2'b11;
            @(posedge i_clock);
            fire <= 1'b0;
            cyc(0);
            {nm, np} = '0;
            cyc(300);
            chk(nm, 3);
            chk(np, 1);
            @(posedge i_clock);
            run <= 1'b0;
        end
        chk(16'((tp - tm) / 20), 16'h00FF);
        test_done();
    end
    initial begin
        repeat (20000) @(posedge i_clock);
        bad_count++;
        test_done();
    end
endmodule : cpt_capture_output_tb
`default_nettype wire
